/* File: rtl/wdtit_top.sv */
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - With watchdog enabled, counter advances on the independent watchdog oscillator only.
// - Enabled watchdog resets the CPU on timeout; software cannot stop it.
// - Disabled watchdog runs as interval timer raising an interrupt, never a reset.
// - Three-bit select chooses one of eight periods, 16 ms to about 2.1 s.
// - With watchdog enabled, only the first control write after reset takes effect.
// - Counting continues without the CPU clock, so a dead oscillator causes reset.
// - Another chip reset source holds the watchdog inactive while it lasts.
// - A feed is key 1E then key E1 written to the feed register.
// - Other accesses between the two key writes do not spoil the feed.
// - A wrong sequence only sets the bad-feed status; timeout stays at its scheduled moment.
// - Timeout drives the internal reset for about one microsecond.
// - Timeout in power down restarts the oscillator; run resumes once it is stable.
module wdtit_top #(
  parameter logic [16:0] BASE_TICKS = wdtit_pkg::WDT_BASE_TICKS  // Ticks of the shortest period
) (
  input  wire logic                          pclk,             // APB clock, 25 MHz
  input  wire logic                          presetn,          // Async reset, active low
  input  wire logic                          psel,             // APB select
  input  wire logic                          penable,          // APB access phase
  input  wire logic                          pwrite,           // APB direction
  input  wire logic [wdtit_pkg::ADDR_W-1:0]  paddr,            // APB byte address
  input  wire logic [31:0]                   pwdata,           // APB write data
  output logic      [31:0]                   prdata,           // APB read data
  output logic                               pready,           // APB ready
  output logic                               pslverr,          // APB error, unmapped address
  input  wire logic                          wdt_osc_clk,      // Independent watchdog oscillator
  input  wire logic                          watchdog_function_enable_cfg, // Config bit, 1 = watchdog
  input  wire logic                          other_reset,      // Power-on, brownout or pin reset
  input  wire logic                          power_down,       // Chip in power down
  input  wire logic                          osc_stable,       // Main oscillator stable
  output logic                               wdt_cpu_reset,    // Internal CPU reset, active high
  output logic                               osc_restart_req,  // Start main oscillator
  output logic                               exec_hold,        // Hold execution until stable
  output logic                               irq               // Level interrupt
);
  import wdtit_pkg::*;

  // ==========================================================================
  // Input synchronisation
  // ==========================================================================
  logic [SYNC_W-1:0] sync_q;
  logic              osc_s;
  logic              cfg_s;
  logic              other_s;
  logic              pd_s;
  logic              stable_s;

  wdtit_sync u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d_in  ({osc_stable, power_down, other_reset, watchdog_function_enable_cfg, wdt_osc_clk}),
    .q_out (sync_q)
  );

  assign osc_s    = sync_q[0];
  assign cfg_s    = sync_q[1];
  assign other_s  = sync_q[2];
  assign pd_s     = sync_q[3];
  assign stable_s = sync_q[4];

  // ==========================================================================
  // State declarations
  // ==========================================================================
  logic                  wd_on_r;
  logic [1:0]            cfg_age_r;
  logic                  osc_prev_r;
  logic [CTRL_W-1:0]     ctrl_r;
  logic                  ctrl_once_r;
  logic                  feed_armed_r;
  logic [ST_W-1:0]       stat_r;
  logic [ST_W-1:0]       mask_r;
  logic [CNT_W-1:0]      cnt_r;
  logic [PULSE_W-1:0]    pulse_cnt_r;
  logic                  wake_pend_r;
  wdtit_rst_state_t      rs_r;

  // Address decode shared by the read and write paths
  function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] a, output logic hit);
    hit = 1'b1;
    if (a == OFS_CTRL) begin
      reg_index = 3'h0;
    end else if (a == OFS_FEED) begin
      reg_index = 3'h1;
    end else if (a == OFS_STAT) begin
      reg_index = 3'h2;
    end else if (a == OFS_MASK) begin
      reg_index = 3'h3;
    end else if (a == OFS_COUNT) begin
      reg_index = 3'h4;
    end else begin
      reg_index = 3'h7;
      hit       = 1'b0;
    end
  endfunction : reg_index

  // ==========================================================================
  // APB slave: one wait state, read data captured as pready rises, write data as the access ends
  // ==========================================================================
  logic       acc_first;
  logic       fire;
  logic       addr_hit;
  logic [2:0] addr_idx;
  logic       wr_ctrl;
  logic       wr_feed;
  logic       wr_mask;
  logic       rd_stat;

  always_comb begin
    addr_idx = reg_index(paddr, addr_hit);
  end

  assign acc_first = psel & penable & ~pready;
  assign fire      = psel & penable & pready;
  assign wr_ctrl   = fire & pwrite & (addr_idx == 3'h0);
  assign wr_feed   = fire & pwrite & (addr_idx == 3'h1);
  assign wr_mask   = fire & pwrite & (addr_idx == 3'h3);
  assign rd_stat   = fire & ~pwrite & (addr_idx == 3'h2);

  // Handshake and error flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc_first;
      pslverr <= acc_first & ~addr_hit;
    end
  end

  // Read data is sampled one edge before the access ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (acc_first && !pwrite) begin
      if (addr_idx == 3'h0) begin
        prdata <= {26'h0, wd_on_r, ctrl_once_r, ctrl_r};
      end else if (addr_idx == 3'h2) begin
        prdata <= {29'h0, stat_r};
      end else if (addr_idx == 3'h3) begin
        prdata <= {29'h0, mask_r};
      end else if (addr_idx == 3'h4) begin
        prdata <= {15'h0, cnt_r};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================================
  // Configuration strap, caught once the synchroniser has filled after reset
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_age_r <= 2'h0;
      wd_on_r   <= 1'b0;
    end else if (cfg_age_r != 2'h3) begin
      cfg_age_r <= cfg_age_r + 2'h1;
      wd_on_r   <= (cfg_age_r == 2'h2) ? cfg_s : wd_on_r;
    end
  end

  // ==========================================================================
  // Control register and feed sequence; chip resets restore them
  // ==========================================================================
  logic int_rst;
  logic feed_done;
  logic feed_bad;

  assign int_rst   = other_s | wdt_cpu_reset;
  assign feed_done = wr_feed & feed_armed_r & (pwdata[7:0] == KEY_SECOND);
  assign feed_bad  = wr_feed & (pwdata[7:0] != KEY_FIRST) & ~feed_done;

  // Watchdog mode locks control after the first write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r      <= CTRL_RST;
      ctrl_once_r <= 1'b0;
    end else if (int_rst) begin
      ctrl_r      <= CTRL_RST;
      ctrl_once_r <= 1'b0;
    end else if (wr_ctrl && !(wd_on_r && ctrl_once_r)) begin
      ctrl_r      <= pwdata[CTRL_W-1:0];
      ctrl_once_r <= wd_on_r;
    end
  end

  // Arming survives unrelated accesses; a first key always re-arms
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      feed_armed_r <= 1'b0;
    end else if (int_rst) begin
      feed_armed_r <= 1'b0;
    end else if (wr_feed) begin
      feed_armed_r <= (pwdata[7:0] == KEY_FIRST);
    end
  end

  // ==========================================================================
  // Period counter on the watchdog oscillator
  // ==========================================================================
  logic              osc_tick;
  logic              running;
  logic [CNT_W-1:0]  limit;
  logic              expire;

  assign osc_tick = osc_s & ~osc_prev_r;
  assign running  = wd_on_r | ctrl_r[CTRL_RUN];
  assign limit    = wdtit_limit(ctrl_r[SEL_W-1:0], BASE_TICKS);
  assign expire   = running & ~int_rst & osc_tick & (cnt_r == limit - 17'h1);

  // Edge memory of the synchronised oscillator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_prev_r <= 1'b0;
    end else begin
      osc_prev_r <= osc_s;
    end
  end

  // Independent of any CPU clock state, so a failed oscillator still expires
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
    end else if (int_rst) begin
      cnt_r <= '0;
    end else if (feed_done) begin
      cnt_r <= '0;
    end else if (running && osc_tick) begin
      cnt_r <= expire ? '0 : cnt_r + 17'h1;
    end
  end

  // ==========================================================================
  // Reset pulse and power-down wake sequencer
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rs_r            <= RS_IDLE;
      pulse_cnt_r     <= '0;
      wake_pend_r     <= 1'b0;
      wdt_cpu_reset   <= 1'b0;
      osc_restart_req <= 1'b0;
      exec_hold       <= 1'b0;
    end else begin
      case (rs_r)
        RS_IDLE: begin
          if (expire && wd_on_r) begin
            rs_r            <= RS_PULSE;
            pulse_cnt_r     <= '0;
            wdt_cpu_reset   <= 1'b1;
            wake_pend_r     <= pd_s;
            osc_restart_req <= pd_s;
          end
        end
        RS_PULSE: begin
          if (pulse_cnt_r == PULSE_W'(RST_PULSE_CYC - 1)) begin
            wdt_cpu_reset <= 1'b0;
            rs_r          <= wake_pend_r ? RS_WAKE : RS_IDLE;
            exec_hold     <= wake_pend_r;
          end else begin
            pulse_cnt_r <= pulse_cnt_r + 5'h01;
          end
        end
        RS_WAKE: begin
          if (stable_s) begin
            exec_hold       <= 1'b0;
            osc_restart_req <= 1'b0;
            wake_pend_r     <= 1'b0;
            rs_r            <= RS_IDLE;
          end
        end
        default: begin
          rs_r <= RS_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Sticky status, mask and interrupt
  // ==========================================================================
  logic [ST_W-1:0] stat_set;

  assign stat_set = {feed_bad, expire & ~wd_on_r, expire & wd_on_r};

  // Read clears only what the read returned; a new set always wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= '0;
    end else begin
      stat_r <= (stat_r & ~(rd_stat ? prdata[ST_W-1:0] : 3'h0)) | stat_set;
    end
  end

  // Interrupt enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= MASK_RST;
    end else if (wr_mask) begin
      mask_r <= pwdata[ST_W-1:0];
    end
  end

  // Registered output; lags the status by one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_r & mask_r);
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_pulse_full;
    wdt_cpu_reset throughout (##24 1'b1);
  endsequence

  sequence s_pulse_end;
    ##1 !wdt_cpu_reset;
  endsequence

  AST_FEED_CLEARS: assert property (feed_done && !int_rst |=> cnt_r == '0)
    else $error("feed did not restart the count");

  AST_PULSE_LEN: assert property ($rose(wdt_cpu_reset) |-> s_pulse_full ##0 s_pulse_end)
    else $error("watchdog reset pulse length wrong");

  AST_WD_RESET: assert property (expire && wd_on_r && rs_r == RS_IDLE |=> wdt_cpu_reset)
    else $error("timeout without reset");

  AST_INTERVAL: assert property (expire && !wd_on_r |=> !$rose(wdt_cpu_reset) && stat_r[ST_INTV])
    else $error("interval timeout misbehaved");

  AST_LOCK: assert property (wr_ctrl && wd_on_r && ctrl_once_r && !int_rst |=> $stable(ctrl_r))
    else $error("locked control register changed");

  AST_HOLD: assert property (other_s |=> cnt_r == '0 && rs_r == RS_IDLE)
    else $error("watchdog active during other reset");

  AST_KEY_ORDER: assert property (wr_feed && !feed_armed_r && pwdata[7:0] == KEY_SECOND
                                  |=> stat_r[ST_BADFEED])
    else $error("feed accepted without first key");

  AST_DISCARD: assert property (wr_feed && feed_armed_r && pwdata[7:0] != KEY_FIRST
                                && pwdata[7:0] != KEY_SECOND |=> !feed_armed_r)
    else $error("partial feed kept after wrong key");

  AST_ARM_KEEP: assert property (feed_armed_r && !wr_feed && !int_rst |=> feed_armed_r)
    else $error("arming lost on unrelated access");

  AST_WRONG_NOACT: assert property (feed_bad && !int_rst && !osc_tick |=> $stable(cnt_r))
    else $error("wrong feed changed the count");

  AST_WAKE: assert property (rs_r == RS_WAKE && !stable_s |=> exec_hold && osc_restart_req)
    else $error("execution resumed before oscillator stable");

  AST_TICK_ONLY: assert property (!osc_tick && !feed_done && !int_rst |=> $stable(cnt_r))
    else $error("count moved without oscillator edge");

endmodule : wdtit_top

/* File: rtl/wdtit_pkg.sv */
package wdtit_pkg;

  // ==========================================================================
  // Register map (byte addresses, one 32-bit word each)
  // ==========================================================================
  localparam int          ADDR_W     = 12;
  localparam logic [11:0] OFS_CTRL   = 12'h000;  // Timeout select, interval run, lock
  localparam logic [11:0] OFS_FEED   = 12'h004;  // Key writes, reads zero
  localparam logic [11:0] OFS_STAT   = 12'h008;  // Sticky events, read clears
  localparam logic [11:0] OFS_MASK   = 12'h00C;  // Interrupt enables, same layout
  localparam logic [11:0] OFS_COUNT  = 12'h010;  // Live counter value

  // ==========================================================================
  // Field layouts and reset values
  // ==========================================================================
  localparam int          SEL_W      = 3;
  localparam int          CTRL_W     = 4;
  localparam int          CTRL_RUN   = 3;        // Interval timer run, only without watchdog
  localparam int          CTRL_LOCK  = 4;        // Read-back: control write used up
  localparam int          CTRL_WDON  = 5;        // Read-back: watchdog function active
  localparam logic [3:0]  CTRL_RST   = 4'h7;     // Longest period, interval timer stopped
  localparam int          ST_W       = 3;
  localparam int          ST_WDTO    = 0;        // Watchdog timeout reset issued
  localparam int          ST_INTV    = 1;        // Interval period elapsed
  localparam int          ST_BADFEED = 2;        // Key write out of order
  localparam logic [2:0]  MASK_RST   = 3'h0;
  localparam logic [7:0]  KEY_FIRST  = 8'h1E;
  localparam logic [7:0]  KEY_SECOND = 8'hE1;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int          CLK_HZ       = 25_000_000;
  localparam int          RST_PULSE_NS = 1000;
  localparam int          RST_PULSE_CYC = (RST_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int          PULSE_W      = 5;
  localparam int          TO_MIN_MS    = 16;
  localparam int          TO_MAX_MS    = 2100;     // Nominal upper end, 16 ms doubled 7 times
  localparam int          WDT_OSC_HZ   = 32_000;   // Nominal watchdog RC oscillator rate
  localparam int          CNT_W        = 17;
  localparam logic [16:0] WDT_BASE_TICKS = 17'(TO_MIN_MS * WDT_OSC_HZ / 1000);
  localparam int          SYNC_W       = 5;

  // ==========================================================================
  // Reset sequencer states
  // ==========================================================================
  typedef enum logic [1:0] {
    RS_IDLE  = 2'b00,
    RS_PULSE = 2'b01,
    RS_WAKE  = 2'b10
  } wdtit_rst_state_t;

  // Ticks of one full period for a select code
  function automatic logic [16:0] wdtit_limit(input logic [2:0] sel, input logic [16:0] base);
    wdtit_limit = base << sel;
  endfunction : wdtit_limit

endpackage : wdtit_pkg

/* File: rtl/wdtit_sync.sv */
`timescale 1ns/1ps
module wdtit_sync (
  input  wire logic                          clk,      // Destination clock
  input  wire logic                          rst_n,    // Async reset, active low
  input  wire logic [wdtit_pkg::SYNC_W-1:0]  d_in,     // Asynchronous levels
  output logic      [wdtit_pkg::SYNC_W-1:0]  q_out     // Synchronised levels
);
  import wdtit_pkg::*;

  logic [SYNC_W-1:0] meta_r;

  // ==========================================================================
  // Two-stage synchroniser; first stage feeds only the second
  // ==========================================================================
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q_out  <= '0;
    end else begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end

endmodule : wdtit_sync

/* File: tb/test_wdtit_top.sv */
`timescale 1ns/1ps
module test_wdtit_top;
  import wdtit_pkg::*;

  // ==========================================================================
  // Stimulus, observed outputs and bookkeeping
  // ==========================================================================
  // Short base period keeps even the longest select inside the run budget
  localparam logic [16:0] BT = 17'h00004;
  logic        pclk, presetn, psel, penable, pwrite, wdt_osc_clk;
  logic        watchdog_function_enable_cfg, other_reset, power_down, osc_stable;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err, wdt_cpu_reset, osc_restart_req, exec_hold, irq, rst_seen;
  int          mismatches, num_checks, cyc, t0, n, d;

  wdtit_top #(.BASE_TICKS(BT)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wdt_osc_clk(wdt_osc_clk), .watchdog_function_enable_cfg(watchdog_function_enable_cfg),
    .other_reset(other_reset), .power_down(power_down), .osc_stable(osc_stable),
    .wdt_cpu_reset(wdt_cpu_reset), .osc_restart_req(osc_restart_req), .exec_hold(exec_hold), .irq(irq));

  // ==========================================================================
  // Clocks: watchdog oscillator is ten bus cycles per tick, phase unrelated
  // ==========================================================================
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    wdt_osc_clk = 1'b0;
    #7;
    forever #200 wdt_osc_clk = ~wdt_osc_clk;
  end

  // Cycle count, reset watch and hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (wdt_cpu_reset === 1'b1) rst_seen <= 1'b1;
    if (cyc > 60000) begin
      mismatches++;
      conclude();
    end
  end

  // ==========================================================================
  // Tasks
  // ==========================================================================
  task automatic conclude();
    if (mismatches == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int k;
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    cmp("pready", 32'h1, 32'(pready));
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    apb(1'b1, a, v);
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    cmp(what, exp, rd);
  endtask : rdc

  function automatic logic sig(input int w);
    case (w)
      0: sig = wdt_cpu_reset;
      1: sig = irq;
      default: sig = exec_hold;
    endcase
  endfunction : sig

  // Bounded wait for an output level, then compare it
  task automatic waitv(input int w, input logic v, input int lim, input string what);
    int k;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (sig(w) !== v && k < lim);
    cmp(what, 32'(v), 32'(sig(w)));
  endtask : waitv

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
    watchdog_function_enable_cfg = 1'b1; other_reset = 1'b0; power_down = 1'b0; osc_stable = 1'b1;
    mismatches = 0; num_checks = 0; cyc = 0; rst_seen = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    // Watchdog mode: one control write only, feed before setting the period
    rdc(OFS_CTRL, 32'h00000027, "ctrl reset");
    rdc(OFS_MASK, 32'h00000000, "mask reset");
    wr(OFS_FEED, 32'h0000001E);
    wr(OFS_FEED, 32'h000000E1);
    wr(OFS_CTRL, 32'h00000001);
    rdc(OFS_CTRL, 32'h00000031, "ctrl first write");
    wr(OFS_CTRL, 32'h0000000B);
    rdc(OFS_CTRL, 32'h00000031, "ctrl locked");
    rst_seen = 1'b0;
    // Feeds split by a counter read keep the reset away
    repeat (6) begin
      wr(OFS_FEED, 32'h0000001E);
      apb(1'b0, OFS_COUNT, 32'h0);
      wr(OFS_FEED, 32'h000000E1);
      t0 = cyc;
      repeat (20) @(posedge pclk);
    end
    cmp("no reset while fed", 32'h0, 32'(rst_seen));
    // A broken pair must not move the scheduled timeout
    wr(OFS_FEED, 32'h0000001E);
    wr(OFS_FEED, 32'h00000055);
    wr(OFS_FEED, 32'h000000E1);
    waitv(0, 1'b1, 150, "timeout reset");
    cmp("timeout moment", 32'h1, 32'(cyc - t0 >= 70 && cyc - t0 <= 95));
    n = 0;
    while (sig(0) === 1'b1 && n < 40) begin
      n++;
      @(posedge pclk);
    end
    cmp("reset pulse cycles", 32'd25, 32'(n));
    rdc(OFS_STAT, 32'h00000005, "status after timeout");
    rdc(OFS_CTRL, 32'h00000027, "ctrl after timeout");
    // Timeout in power down: oscillator restart, hold until stable
    wr(OFS_CTRL, 32'h00000000);
    power_down <= 1'b1;
    osc_stable <= 1'b0;
    waitv(0, 1'b1, 200, "power down timeout");
    @(posedge pclk);
    cmp("osc restart", 32'h1, 32'(osc_restart_req));
    repeat (40) @(posedge pclk);
    cmp("exec hold", 32'h1, 32'(exec_hold));
    osc_stable <= 1'b1;
    waitv(2, 1'b0, 10, "exec released");
    power_down <= 1'b0;
    repeat (2) @(posedge pclk);
    cmp("osc restart done", 32'h0, 32'(osc_restart_req));
    // Another reset source holds the watchdog off past a whole period
    wr(OFS_FEED, 32'h0000001E);
    wr(OFS_FEED, 32'h000000E1);
    wr(OFS_CTRL, 32'h00000000);
    other_reset <= 1'b1;
    rst_seen = 1'b0;
    repeat (150) @(posedge pclk);
    cmp("held by other reset", 32'h0, 32'(rst_seen));
    other_reset <= 1'b0;
    repeat (3) @(posedge pclk);
    rdc(OFS_CTRL, 32'h00000027, "ctrl after other reset");
    // Interval mode after a fresh reset with the watchdog strap off
    presetn <= 1'b0;
    watchdog_function_enable_cfg <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    rst_seen = 1'b0;
    rdc(OFS_CTRL, 32'h00000007, "ctrl interval reset");
    apb(1'b0, 12'h020, 32'h0);
    cmp("unmapped error", 32'h1, 32'(err));
    wr(OFS_CTRL, 32'h00000008);
    repeat (60) @(posedge pclk);
    cmp("irq masked", 32'h0, 32'(irq));
    rdc(OFS_STAT, 32'h00000002, "status masked");
    wr(OFS_MASK, 32'h00000002);
    rdc(OFS_MASK, 32'h00000002, "mask written");
    // Ascending selects only: a lower limit could strand the running count
    for (int s = 0; s < 8; s++) begin
      wr(OFS_CTRL, 32'h8 | 32'(s));
      rdc(OFS_CTRL, 32'h8 | 32'(s), "ctrl select");
      apb(1'b0, OFS_STAT, 32'h0);                              // Drop a stale flag so t0 marks a real expiry
      waitv(1, 1'b1, 6000, "interval irq");
      t0 = cyc;
      rdc(OFS_STAT, 32'h00000002, "interval status");
      waitv(1, 1'b1, 6000, "interval irq");
      d = cyc - t0 - (40 << s);
      cmp("interval period", 32'h1, 32'(d >= -5 && d <= 5));
      rdc(OFS_STAT, 32'h00000002, "interval status");
    end
    cmp("no reset in interval mode", 32'h0, 32'(rst_seen));
    conclude();
  end

endmodule : test_wdtit_top
